// *** rtl/wtg_pkg.sv ***
// Package of constants for the timeout guard block
package wtg_pkg;
  // Register map (byte addresses, one word each)
  localparam logic [7:0]  GUARD_CONTROL_REG_ADDR = 8'h0D;  // Printed address
  localparam logic [7:0]  GUARD_OPTION_ADDR      = 8'h10;  // Option status
  // Field positions in guard_control_reg
  localparam int          ACTIVATE_BIT           = 7;
  localparam int          COUNT_TOP_BIT          = 6;
  // Reset values
  localparam logic [7:0]  GUARD_CONTROL_RESET    = 8'h7F;
  // Timing
  localparam int          PRESCALE_CYCLES        = 65536;
  localparam int          WAKE_DELAY_CYCLES      = 514;
  localparam int          CLK_PERIOD_PS          = 10000;
  localparam int          RESET_PULSE_NS         = 500;
  localparam int          RESET_PULSE_CYCLES     =
    (RESET_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Pulse counter states
  typedef enum logic [0:0] {
    WTG_IDLE  = 1'b0,
    WTG_PULSE = 1'b1
  } wtg_state_t;
endpackage : wtg_pkg

// *** rtl/wtg_timeout_guard.sv ***
// Windowed timeout guard with APB register access
// Operation
// The guard is a seven-bit downcounter that moves on one prescaler tick.
// The prescaler divides the system clock by PRESCALE, so the count steps
// once every PRESCALE cycles whether or not the guard is active. Only the
// generation of the reset pulse depends on the activate bit or on the
// hardware option pin.
//
// Expiry
// An expiry is raised when a tick moves the count from 40h to 3Fh while
// the guard is active. A write that sets activate, or any write while the
// guard is already active, with the top count bit clear also raises an
// expiry at once. This gives software a way to force a device reset.
// The expiry request and the pulse state are both registered, so the pin goes low two edges later.
//
// Reset pulse
// The pulse lasts a fixed number of clock cycles, derived from the pulse
// width and the clock period in the package. The block never resets
// itself: the pin must be looped back to the system reset by the user.
// While the pulse runs, further expiry requests are ignored.
//
// Low power
// Wait mode has no effect on counting; its level is only readable.
// Halt mode freezes both the prescaler and the count as soon as the
// filtered halt level is seen. Leaving halt on a wake interrupt starts a
// hold-off counter; counting resumes only after the wake delay. A reset
// during halt clears everything, including the halted flag.
//
// Hazards
// The option, halt, wake and wait pins are asynchronous. Each passes
// three flip-flops and its level changes only when the last two agree,
// so a single-cycle glitch is never taken as a level change.
// A write and a tick in the same cycle: the write wins and the tick is
// lost; the prescaler phase is not disturbed by the write.
// Read data is captured in the setup phase and held for the access
// phase, so a tick during the access does not tear the read word.
//
// Limitations
// Only byte lane 0 of the write strobe is looked at.
// The option register is read only; writes to it are ignored.
// Unmapped addresses answer with an error and have no effect.
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module wtg_timeout_guard
  import wtg_pkg::*;
#(
  parameter int PRESCALE = PRESCALE_CYCLES
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_b_in,
  input  wire logic        hw_option_in,
  input  wire logic        wait_mode_in,
  input  wire logic        halt_mode_in,
  input  wire logic        wake_irq_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  input  wire logic [3:0]  pstrb_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  output logic             reset_pin_b_out,
  output logic             reset_pulse_out
);

  localparam int PW = $clog2(PRESCALE);
  localparam int WW = $clog2(WAKE_DELAY_CYCLES + 1);
  localparam int RW = $clog2(RESET_PULSE_CYCLES + 1);

  logic             activate;
  logic [6:0]       count;
  logic [PW-1:0]    prescale;
  logic             halted;
  logic [WW-1:0]    wake_cnt;
  logic             expire_req;
  wtg_state_t       state;
  logic [RW-1:0]    pulse_cnt;
  logic [2:0]       hw_sync;
  logic [2:0]       wait_sync;
  logic [2:0]       halt_sync;
  logic [2:0]       wake_sync;
  logic             hw_opt;
  logic             halt_lvl;
  logic             wake_lvl;
  logic             wait_lvl;

  logic             next_activate;
  logic [6:0]       next_count;
  logic [PW-1:0]    next_prescale;
  logic             next_halted;
  logic [WW-1:0]    next_wake_cnt;
  logic             next_expire_req;
  wtg_state_t       next_state;
  logic [RW-1:0]    next_pulse_cnt;
  logic             next_hw_opt;
  logic             next_halt_lvl;
  logic             next_wake_lvl;
  logic             next_wait_lvl;

  logic             wr_ctrl;
  logic             tick;
  logic             guard_on;
  logic             running;
  logic [6:0]       wr_count;
  logic             wr_activate;

  // Address decode shared by read and write paths
  function automatic logic hit_ctrl(input logic [7:0] a);
    hit_ctrl = (a == GUARD_CONTROL_REG_ADDR);
  endfunction : hit_ctrl

  function automatic logic hit_opt(input logic [7:0] a);
    hit_opt = (a == GUARD_OPTION_ADDR);
  endfunction : hit_opt

  // APB handshake: zero wait states, error on unmapped
  always_comb begin
    pready_out  = 1'b1;
    pslverr_out = psel_in && penable_in &&
                  !hit_ctrl(paddr_in) && !hit_opt(paddr_in);
    wr_ctrl     = psel_in && penable_in && pwrite_in &&
                  hit_ctrl(paddr_in) && pstrb_in[0];
    wr_count    = pwdata_in[COUNT_TOP_BIT:0];
    wr_activate = pwdata_in[ACTIVATE_BIT];
  end

  // Read data, registered by the bus process
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (psel_in && !penable_in && !pwrite_in) begin
      if (hit_ctrl(paddr_in)) begin
        next_rdata = {24'h00_0000, activate, count};
      end else if (hit_opt(paddr_in)) begin
        next_rdata = {29'h0000_0000, halted, wait_lvl, hw_opt};
      end
    end else if (psel_in) begin
      next_rdata = rdata;
    end
  end
  assign prdata_out = rdata;

  // Pin level filtering: change accepted when stages 2 and 3 agree
  always_comb begin
    next_hw_opt   = (hw_sync[1] == hw_sync[2]) ? hw_sync[2] : hw_opt;
    next_halt_lvl = (halt_sync[1] == halt_sync[2]) ? halt_sync[2]
                                                   : halt_lvl;
    next_wake_lvl = (wake_sync[1] == wake_sync[2]) ? wake_sync[2]
                                                   : wake_lvl;
    next_wait_lvl = (wait_sync[1] == wait_sync[2]) ? wait_sync[2]
                                                   : wait_lvl;
  end

  // Core guard logic: prescaler, count, halt, expiry
  always_comb begin
    guard_on        = activate || hw_opt;
    running         = !halted && !halt_lvl;
    tick            = running &&
                      (prescale == PW'(PRESCALE - 1));
    next_activate   = activate;
    next_count      = count;
    next_prescale   = prescale;
    next_halted     = halted;
    next_wake_cnt   = wake_cnt;
    next_expire_req = 1'b0;
    if (running) begin
      next_prescale = tick ? '0 : prescale + 1'b1;
    end
    if (halt_lvl && !halted) begin
      next_halted = 1'b1;
      next_wake_cnt = '0;
    end else if (halted && wake_lvl && !halt_lvl) begin
      // Hold off counting after wake
      if (wake_cnt == WW'(WAKE_DELAY_CYCLES - 1)) begin
        next_halted = 1'b0;
      end else begin
        next_wake_cnt = wake_cnt + 1'b1;
      end
    end
    if (wr_ctrl) begin
      // Writes may only set activation
      next_activate = activate | wr_activate;
      next_count    = wr_count;
      if ((wr_activate || guard_on) && !wr_count[COUNT_TOP_BIT]) begin
        next_expire_req = 1'b1;
      end
    end else if (tick) begin
      next_count = count - 7'h01;
      if (guard_on && count == 7'h40) begin
        next_expire_req = 1'b1;
      end
    end
  end

  // Reset pulse generator
  always_comb begin
    next_state     = state;
    next_pulse_cnt = pulse_cnt;
    case (state)
      WTG_IDLE: begin
        if (expire_req) begin
          next_state     = WTG_PULSE;
          next_pulse_cnt = '0;
        end
      end
      WTG_PULSE: begin
        if (pulse_cnt == RW'(RESET_PULSE_CYCLES - 1)) begin
          next_state = WTG_IDLE;
        end else begin
          next_pulse_cnt = pulse_cnt + 1'b1;
        end
      end
      default: next_state = WTG_IDLE;
    endcase
  end

  // Output drive, pin low and pulse output high while pulsing
  always_comb begin
    reset_pin_b_out = (state != WTG_PULSE);
    reset_pulse_out = (state == WTG_PULSE);
  end

  // Register all state; reset restores deactivated value
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      activate   <= GUARD_CONTROL_RESET[ACTIVATE_BIT];
      count      <= GUARD_CONTROL_RESET[COUNT_TOP_BIT:0];
      prescale   <= '0;
      halted     <= 1'b0;
      wake_cnt   <= '0;
      expire_req <= 1'b0;
      state      <= WTG_IDLE;
      pulse_cnt  <= '0;
      hw_sync    <= 3'h0;
      wait_sync  <= 3'h0;
      halt_sync  <= 3'h0;
      wake_sync  <= 3'h0;
      hw_opt     <= 1'b0;
      halt_lvl   <= 1'b0;
      wake_lvl   <= 1'b0;
      wait_lvl   <= 1'b0;
      rdata      <= 32'h0000_0000;
    end else begin
      activate   <= next_activate;
      count      <= next_count;
      prescale   <= next_prescale;
      halted     <= next_halted;
      wake_cnt   <= next_wake_cnt;
      expire_req <= next_expire_req;
      state      <= next_state;
      pulse_cnt  <= next_pulse_cnt;
      hw_sync    <= {hw_sync[1:0], hw_option_in};
      wait_sync  <= {wait_sync[1:0], wait_mode_in};
      halt_sync  <= {halt_sync[1:0], halt_mode_in};
      wake_sync  <= {wake_sync[1:0], wake_irq_in};
      hw_opt     <= next_hw_opt;
      halt_lvl   <= next_halt_lvl;
      wake_lvl   <= next_wake_lvl;
      wait_lvl   <= next_wait_lvl;
      rdata      <= next_rdata;
    end
  end

endmodule : wtg_timeout_guard

// *** testbench/wtg_monitor.sv ***
// Port checker for the timeout guard
`timescale 1ns/1ps
module wtg_monitor
  import wtg_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        rst_b_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        reset_pin_b_out,
  input wire logic        reset_pulse_out
);
  logic [6:0] low_cnt;
  logic [6:0] next_low_cnt;
  logic       mapped;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // Length of the running reset pulse
  assign mapped = paddr_in == GUARD_CONTROL_REG_ADDR ||
                  paddr_in == GUARD_OPTION_ADDR;
  always_comb next_low_cnt = reset_pin_b_out ? 7'h00 : low_cnt + 7'h01;
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) low_cnt <= 7'h00;
    else low_cnt <= next_low_cnt;
  end
  // Bus phases
  sequence acc_s; psel_in && penable_in; endsequence
  sequence ctl_s; acc_s ##0 paddr_in == GUARD_CONTROL_REG_ADDR; endsequence
  sequence force_s;
    ctl_s ##0 (pwrite_in && pstrb_in[0] && pwdata_in[7:6] == 2'b10);
  endsequence
  pulse_len_a: assert property ($rose(reset_pin_b_out) |-> low_cnt == 7'h32)
    else $error("reset pulse length wrong");
  pulse_max_a: assert property (low_cnt <= 7'h32)
    else $error("reset pulse too long");
  force_rst_a: assert property (force_s |-> ##2 !reset_pin_b_out)
    else $error("forced reset missing");
  pulse_copy_a: assert property (reset_pulse_out == !reset_pin_b_out)
    else $error("pulse copy differs");
  bus_ready_a: assert property (acc_s |-> pready_out)
    else $error("no ready in access");
  bad_addr_a: assert property (acc_s ##0 !mapped |-> pslverr_out)
    else $error("no error on unmapped");
  good_addr_a: assert property (acc_s ##0 mapped |-> !pslverr_out)
    else $error("error on mapped");
  upper_zero_a: assert property (ctl_s ##0 !pwrite_in |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
endmodule : wtg_monitor
bind wtg_timeout_guard wtg_monitor mon_u (.clk_sys_in(clk_sys_in),
  .rst_b_in(rst_b_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pstrb_in(pstrb_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .reset_pin_b_out(reset_pin_b_out),
  .reset_pulse_out(reset_pulse_out));

// *** testbench/windowed_watchdog_timer_tb_top.sv ***
// Self-checking bench for the timeout guard
`timescale 1ns/1ps
module windowed_watchdog_timer_tb_top
  import wtg_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        wait_mode = 1'b0;
  logic        hw_opt = 1'b0;
  logic        halt = 1'b0;
  logic        wake = 1'b0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_b;
  logic [31:0] rd;
  logic        er;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          n;
  int          w;
  // Clock
  always #5 clk = ~clk;
  wtg_timeout_guard #(.PRESCALE(16)) dut_u (.clk_sys_in(clk),
    .rst_b_in(rst_b), .hw_option_in(hw_opt), .wait_mode_in(wait_mode),
    .halt_mode_in(halt), .wake_irq_in(wake), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr),
    .reset_pin_b_out(pin_b), .reset_pulse_out());
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_reset;
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
  endtask : do_reset
  task automatic wait_low(input int lim);
    n = 0;
    while (pin_b === 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
  endtask : wait_low
  task automatic t_regs;
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(rd, 32'h7F);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'(er), 32'h1);
    $display("regs done");
  endtask : t_regs
  task automatic t_free;
    apb(1'b1, GUARD_CONTROL_REG_ADDR, 32'h41);
    wait_low(60);
    chk(32'(pin_b), 32'h1);
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(32'(rd[7:0] >= 8'h3C && rd[7:0] <= 8'h3E), 32'h1);
    $display("free run done");
  endtask : t_free
  task automatic t_expire;
    @(posedge clk);
    wait_mode <= 1'b1;
    apb(1'b1, GUARD_CONTROL_REG_ADDR, 32'hC5);
    wait_low(200);
    chk(32'(n >= 83 && n <= 98), 32'h1);
    w = 0;
    while (pin_b === 1'b0 && w < 100) begin
      @(negedge clk);
      w++;
    end
    chk(w, 32'd50);
    $display("expiry done");
  endtask : t_expire
  task automatic t_sticky;
    apb(1'b1, GUARD_CONTROL_REG_ADDR, 32'h7F);
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(32'(rd[7]), 32'h1);
    do_reset;
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(rd, 32'h7F);
    $display("sticky done");
  endtask : t_sticky
  task automatic t_force;
    apb(1'b1, GUARD_CONTROL_REG_ADDR, 32'h80);
    wait_low(10);
    chk(n, 32'd2);
    repeat (60) @(negedge clk);
    $display("force done");
  endtask : t_force
  task automatic t_halt;
    logic [31:0] c1;
    do_reset;
    apb(1'b1, GUARD_CONTROL_REG_ADDR, 32'hC5);
    halt <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    c1 = rd;
    repeat (100) @(posedge clk);
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(rd, c1);
    chk(32'(pin_b), 32'h1);
    apb(1'b0, GUARD_OPTION_ADDR, 32'h0);
    chk(rd & 32'h4, 32'h4);
    halt <= 1'b0;
    wake <= 1'b1;
    repeat (400) @(posedge clk);
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(rd, c1);
    repeat (150) @(posedge clk);
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(32'(rd[6:0] < c1[6:0] && rd[6]), 32'h1);
    wake <= 1'b0;
    halt <= 1'b1;
    repeat (6) @(posedge clk);
    halt <= 1'b0;
    do_reset;
    apb(1'b0, GUARD_CONTROL_REG_ADDR, 32'h0);
    chk(rd, 32'h7F);
    $display("halt done");
  endtask : t_halt
  task automatic t_hwopt;
    do_reset;
    hw_opt <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, GUARD_OPTION_ADDR, 32'h0);
    chk(rd & 32'h1, 32'h1);
    apb(1'b1, GUARD_CONTROL_REG_ADDR, 32'h3F);
    wait_low(10);
    chk(n, 32'd2);
    repeat (60) @(posedge clk);
    hw_opt <= 1'b0;
    $display("hw option done");
  endtask : t_hwopt
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      print_verdict;
    end
  end
  // Main sequence
  initial begin
    do_reset;
    t_regs;
    t_free;
    t_expire;
    t_sticky;
    t_force;
    t_halt;
    t_hwopt;
    print_verdict;
  end
endmodule : windowed_watchdog_timer_tb_top
